// ---- pkg/fpx_regs.svh ----
`ifndef FPX_REGS_SVH
`define FPX_REGS_SVH
// ----------------------------------------------------------------
// Register selects for the move port
// ----------------------------------------------------------------
`define FPX_SEL_CTRL 2'h0
`define FPX_SEL_STAT 2'h1
`define FPX_SEL_FIAR 2'h2
// ----------------------------------------------------------------
// Status word field positions
// ----------------------------------------------------------------
`define FPX_CC_LSB 24
`define FPX_QB_LSB 16
`define FPX_CUR_LSB 8
`define FPX_STK_LSB 3
// ----------------------------------------------------------------
// Current fault bit positions (same in enable byte)
// ----------------------------------------------------------------
`define FPX_F_BSUN 7
`define FPX_F_SIGNALLING_NOT_A_NUMBER 6
`define FPX_F_OPERAND_ERROR 5
`define FPX_F_OVERFLOW_BIT 4
`define FPX_F_UNDERFLOW_BIT 3
`define FPX_F_DZ 2
`define FPX_F_SECOND_ROUNDING_LOSS 1
`define FPX_F_FIRST_ROUNDING_LOSS 0
// ----------------------------------------------------------------
// Mantissa precision widths and reset values
// ----------------------------------------------------------------
`define FPX_MANT_EXT 7'h40
`define FPX_MANT_SGL 7'h18
`define FPX_MANT_DBL 7'h35
`define FPX_CTRL_RST 16'h0000
`define FPX_STAT_RST 32'h0000_0000
`define FPX_FIAR_RST 32'h0000_0000
`endif

// ---- pkg/fpx_pkg.sv ----
package fpx_pkg;
   typedef enum logic [1:0] {
      FPX_ROUND_WIDTH_SELECT_EXT = 2'h0,
      FPX_ROUND_WIDTH_SELECT_SGL = 2'h1,
      FPX_ROUND_WIDTH_SELECT_DBL = 2'h2
   } fpx_round_width_select_e;
   typedef enum logic [2:0] {
      FPX_ST_IDLE = 3'h1,
      FPX_ST_EXEC = 3'h2,
      FPX_ST_DONE = 3'h4
   } fpx_state_e;
endpackage

// ---- verilog/fpx_round_mask.sv ----
`timescale 1ns/10ps
`include "fpx_regs.svh"
// Forces mantissa bits below the selected precision to zero and clamps the
// exponent into the narrower format's range for register and memory destinations.
module fpx_round_mask (
   input wire logic [1:0] round_width_select_i, // Precision select
   input wire logic mem_dest_i, // Destination is memory
   input wire logic [1:0] mem_fmt_i, // Memory format precision
   input wire logic [63:0] mant_i, // Rounded mantissa
   input wire logic [14:0] exp_i, // Biased extended exponent
   output logic [63:0] mant_o, // Masked mantissa
   output logic [14:0] exp_o, // Range-limited exponent
   output logic [6:0] width_o // Active mantissa width
);
   logic [1:0] eff;
   logic [63:0] keep;
   logic [14:0] lo;
   logic [14:0] hi;
   always_comb begin
      eff = mem_dest_i ? mem_fmt_i : round_width_select_i;
      case (eff)
         fpx_pkg::FPX_ROUND_WIDTH_SELECT_SGL: width_o = `FPX_MANT_SGL;
         fpx_pkg::FPX_ROUND_WIDTH_SELECT_DBL: width_o = `FPX_MANT_DBL;
         default: width_o = `FPX_MANT_EXT;
      endcase
      keep = ~(64'hFFFF_FFFF_FFFF_FFFF >> width_o);
      mant_o = mant_i & keep;
      case (eff)
         fpx_pkg::FPX_ROUND_WIDTH_SELECT_SGL: begin
            lo = 15'h3F81;
            hi = 15'h407E;
         end
         fpx_pkg::FPX_ROUND_WIDTH_SELECT_DBL: begin
            lo = 15'h3C01;
            hi = 15'h43FE;
         end
         default: begin
            lo = 15'h0000;
            hi = 15'h7FFF;
         end
      endcase
      if (exp_i == 15'h7FFF || exp_i == 15'h0000) begin
         exp_o = exp_i;
      end else if (exp_i < lo) begin
         exp_o = lo;
      end else if (exp_i > hi) begin
         exp_o = hi;
      end else begin
         exp_o = exp_i;
      end
   end
endmodule

// ---- verilog/fpx_status_unit.sv ----
`timescale 1ns/10ps
`include "fpx_regs.svh"
// Notes on behaviour
// - Precision select rounds at 64, 24 or 53 mantissa bits.
// - Result is computed unbounded then rounded to selected precision before storing.
// - Register destination: mantissa bits below precision are zero.
// - Narrow precision to register: exponent held within narrower range.
// - Memory destination ignores precision select, uses destination format.
// - Status word fully read/write; reset or null restore clears it.
// - Class bits updated by arithmetic ops, not by move-multiple or control moves.
// - Class bits: sign, zero, infinity, not-a-number; only eight codes.
// - Equal test is zero bit; unordered test is not-a-number bit.
// - Quotient byte holds seven low bits and sign; persists until cleared.
// - Current fault byte cleared at op start unless op cannot fault.
// - Trap when a current fault bit and its enable bit are both set.
// - Detected exception sets current fault bit even if trap disabled.
// - Software write setting current fault bits never traps.
// - Sticky byte five bits; cleared only by status write, reset, null restore.
// - Most ops, not moves, OR combined current faults into sticky byte.
// - Sticky bits combine current faults per the fixed equations.
// - Sticky bit changes neither raise nor suppress an exception.
// - Trapping instruction loads fault address before it executes.
// - Register moves and move-multiple leave fault address unchanged.
// - Reset or null restore clears fault address.
// - Enable bits prioritised bit 15 highest; only highest reported.
// - Zero mode byte selects extended precision, default rounding.
module fpx_status_unit (
   input wire logic clk_sys_i, // 50 MHz processor clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic null_restore_i, // Null-state restore pulse
   input wire logic mv_wr_i, // Register move write strobe
   input wire logic [1:0] mv_sel_i, // Register select for move
   input wire logic [31:0] mv_wdata_i, // Move write data
   output logic [31:0] mv_rdata_o, // Move read data
   input wire logic op_start_i, // Instruction start pulse
   input wire logic op_can_fault_i, // Instruction may raise exceptions
   input wire logic op_is_move_i, // Plain or multiple move instruction
   input wire logic op_arith_i, // Arithmetic op on data registers
   input wire logic [31:0] op_addr_i, // Instruction logical address
   input wire logic op_done_i, // Instruction end pulse
   input wire logic [7:0] op_faults_i, // Exceptions detected during op
   input wire logic res_sign_i, // Result negative
   input wire logic res_zero_i, // Result zero
   input wire logic res_inf_i, // Result infinity
   input wire logic res_nan_i, // Result not-a-number
   input wire logic quot_valid_i, // Quotient produced by op
   input wire logic [7:0] quot_i, // Sign and seven low quotient bits
   input wire logic mem_dest_i, // Destination is memory
   input wire logic [1:0] mem_fmt_i, // Memory destination precision
   input wire logic [63:0] mant_i, // Rounded unbounded mantissa
   input wire logic [14:0] exp_i, // Intermediate exponent
   output logic [63:0] mant_o, // Stored mantissa
   output logic [14:0] exp_o, // Stored exponent
   output logic [6:0] round_width_select_width_o, // Active mantissa width
   output logic [1:0] rounding_mode_field_o, // Rounding mode
   output logic same_value_test_o, // Equal condition
   output logic above_test_o, // Greater condition
   output logic below_test_o, // Less condition
   output logic no_order_test_o, // Unordered condition
   output logic trap_o, // Exception trap request pulse
   output logic [2:0] trap_class_o // Highest enabled class index
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      fpx_pkg::fpx_state_e st;
      logic [15:0] ctrl;
      logic [3:0] cls;
      logic [7:0] quot;
      logic [7:0] cur;
      logic [7:0] hw;
      logic [7:0] stk;
      logic [31:0] fiar;
      logic [31:0] rdata;
      logic trap;
      logic [2:0] tcls;
      logic can_fault;
      logic is_move;
   } fpx_state_s;

   fpx_state_s s_r;
   fpx_state_s s_nxt;
   logic [7:0] hit;
   logic [7:0] acc;
   logic [7:0] cur_now;
   logic [31:0] stat_now;

   function automatic logic [7:0] fpx_accrue(input logic [7:0] f);
      logic [7:0] a;
      a = 8'h00;
      a[7] = f[`FPX_F_SIGNALLING_NOT_A_NUMBER] | f[`FPX_F_OPERAND_ERROR];
      a[6] = f[`FPX_F_OVERFLOW_BIT];
      a[5] = f[`FPX_F_UNDERFLOW_BIT] & f[`FPX_F_SECOND_ROUNDING_LOSS];
      a[4] = f[`FPX_F_DZ];
      a[3] = f[`FPX_F_FIRST_ROUNDING_LOSS] | f[`FPX_F_SECOND_ROUNDING_LOSS] | f[`FPX_F_OVERFLOW_BIT];
      return a;
   endfunction

   function automatic logic [2:0] fpx_top(input logic [7:0] v);
      logic [2:0] k;
      k = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            k = 3'(i);
         end
      end
      return k;
   endfunction

   // ----------------------------------------------------------------
   // Precision datapath
   // ----------------------------------------------------------------
   // Rounding happens upstream on the unbounded result; this stage only
   // narrows what is stored, so no extra rounding error is introduced.
   fpx_round_mask u_mask (
      .round_width_select_i(s_r.ctrl[7:6]),
      .mem_dest_i(mem_dest_i),
      .mem_fmt_i(mem_fmt_i),
      .mant_i(mant_i),
      .exp_i(exp_i),
      .mant_o(mant_o),
      .exp_o(exp_o),
      .width_o(round_width_select_width_o)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.trap = 1'b0;
      cur_now = s_r.cur | op_faults_i;
      // The trap looks only at faults the hardware found in this operation, so bits
      // that software loaded into the current fault byte can never trap.
      hit = (s_r.hw | op_faults_i) & s_r.ctrl[15:8];
      acc = fpx_accrue(cur_now);
      stat_now = {4'h0, s_r.cls, s_r.quot, s_r.cur, s_r.stk};
      case (s_r.st)
         fpx_pkg::FPX_ST_IDLE: begin
            if (op_start_i) begin
               s_nxt.st = fpx_pkg::FPX_ST_EXEC;
               s_nxt.can_fault = op_can_fault_i;
               s_nxt.is_move = op_is_move_i;
               if (op_can_fault_i) begin
                  s_nxt.cur = 8'h00;
                  s_nxt.hw = 8'h00;
                  s_nxt.fiar = op_addr_i;
               end
            end
         end
         fpx_pkg::FPX_ST_EXEC: begin
            if (s_r.can_fault) begin
               s_nxt.cur = cur_now;
               s_nxt.hw = s_r.hw | op_faults_i;
            end
            if (op_done_i) begin
               s_nxt.st = fpx_pkg::FPX_ST_IDLE;
               if (op_arith_i) begin
                  s_nxt.cls = {res_sign_i, res_zero_i, res_inf_i, res_nan_i};
               end
               if (quot_valid_i) begin
                  s_nxt.quot = quot_i;
               end
               if (!s_r.is_move && s_r.can_fault) begin
                  s_nxt.stk = s_r.stk | acc;
               end
               // Only hardware-detected faults reach the trap, sticky bits never.
               if (s_r.can_fault && (hit != 8'h00)) begin
                  s_nxt.trap = 1'b1;
                  s_nxt.tcls = fpx_top(hit);
               end
            end
         end
         default: begin
            s_nxt.st = fpx_pkg::FPX_ST_IDLE;
         end
      endcase
      if (mv_wr_i) begin
         case (mv_sel_i)
            `FPX_SEL_CTRL: s_nxt.ctrl = mv_wdata_i[15:0];
            `FPX_SEL_STAT: begin
               s_nxt.cls = mv_wdata_i[27:24];
               s_nxt.quot = mv_wdata_i[23:16];
               // A fault found in the cycle of the write survives it, so no
               // exception record is lost to a racing software write.
               s_nxt.cur = mv_wdata_i[15:8] | (s_nxt.cur & ~s_r.cur);
               s_nxt.stk = {mv_wdata_i[7:3], 3'h0} | (s_nxt.stk & ~s_r.stk);
            end
            `FPX_SEL_FIAR: s_nxt.fiar = mv_wdata_i;
            default: begin
            end
         endcase
      end
      case (mv_sel_i)
         `FPX_SEL_CTRL: s_nxt.rdata = {16'h0000, s_r.ctrl};
         `FPX_SEL_STAT: s_nxt.rdata = stat_now;
         `FPX_SEL_FIAR: s_nxt.rdata = s_r.fiar;
         default: s_nxt.rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || null_restore_i) begin
         s_r.st <= fpx_pkg::FPX_ST_IDLE;
         s_r.ctrl <= `FPX_CTRL_RST;
         {s_r.cls, s_r.quot, s_r.cur, s_r.stk} <= 28'h000_0000;
         s_r.fiar <= `FPX_FIAR_RST;
         s_r.rdata <= 32'h0000_0000;
         s_r.trap <= 1'b0;
         s_r.tcls <= 3'h0;
         s_r.hw <= 8'h00;
         s_r.can_fault <= 1'b0;
         s_r.is_move <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign mv_rdata_o = s_r.rdata;
   assign rounding_mode_field_o = s_r.ctrl[5:4];
   assign same_value_test_o = s_r.cls[2];
   assign no_order_test_o = s_r.cls[0];
   assign above_test_o = ~(s_r.cls[3] | s_r.cls[0] | s_r.cls[2]);
   assign below_test_o = s_r.cls[3] & ~(s_r.cls[0] | s_r.cls[2]);
   assign trap_o = s_r.trap;
   assign trap_class_o = s_r.tcls;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i || null_restore_i);

   a_trap_needs_enable: assert property (trap_o |-> (s_r.cur & s_r.ctrl[15:8]) != 8'h00)
      else $error("trap without enabled fault");
   a_write_no_trap: assert property (mv_wr_i && s_r.st == fpx_pkg::FPX_ST_IDLE |=> !trap_o)
      else $error("status write caused trap");
   a_fiar_load: assert property (
      s_r.st == fpx_pkg::FPX_ST_IDLE && op_start_i && op_can_fault_i && !mv_wr_i
      |=> s_r.fiar == $past(op_addr_i))
      else $error("fault address not loaded");
   a_fiar_hold: assert property (op_start_i && !op_can_fault_i && !mv_wr_i
      |=> $stable(s_r.fiar))
      else $error("fault address changed");
   a_cur_clear: assert property (
      s_r.st == fpx_pkg::FPX_ST_IDLE && op_start_i && op_can_fault_i && !mv_wr_i
      |=> s_r.cur == 8'h00)
      else $error("current faults not cleared");
   a_sticky_keep: assert property (!mv_wr_i |=> (s_r.stk & $past(s_r.stk)) == $past(s_r.stk))
      else $error("sticky bit lost");
   a_class_hold: assert property (!op_arith_i && !mv_wr_i |=> $stable(s_r.cls))
      else $error("class bits changed");
   a_eq_zero: assert property (
      s_r.st == fpx_pkg::FPX_ST_EXEC && op_done_i && op_arith_i && !mv_wr_i
      |=> same_value_test_o == $past(res_zero_i) && no_order_test_o == $past(res_nan_i))
      else $error("equal or unordered wrong");
   a_round_width_select_width: assert property (!mem_dest_i && s_r.ctrl[7:6] == 2'h1
      |-> round_width_select_width_o == 7'h18)
      else $error("single width wrong");
   c_trap_taken: cover property (trap_o);
   c_sticky_set: cover property (s_r.stk != 8'h00);
   c_status_write: cover property (mv_wr_i && mv_sel_i == `FPX_SEL_STAT);
endmodule

// ---- bench/test_fp_status_exception_logic.sv ----
`timescale 1ns/10ps
`include "fpx_regs.svh"
module test_fp_status_exception_logic;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic null_restore_i = 1'b0, mv_wr_i = 1'b0, op_start_i = 1'b0, op_can_fault_i = 1'b0;
   logic op_is_move_i = 1'b0, op_arith_i = 1'b0, op_done_i = 1'b0, quot_valid_i = 1'b0;
   logic res_sign_i = 1'b0, res_zero_i = 1'b0, res_inf_i = 1'b0, res_nan_i = 1'b0;
   logic mem_dest_i = 1'b0;
   logic [1:0] mv_sel_i = 2'h3, mem_fmt_i = 2'h0, rounding_mode_field_o;
   logic [31:0] mv_wdata_i = 32'h0, op_addr_i = 32'h0, mv_rdata_o, v, w;
   logic [7:0] op_faults_i = 8'h00, quot_i = 8'h00;
   logic [63:0] mant_i = 64'h0, mant_o;
   logic [14:0] exp_i = 15'h0, exp_o;
   logic [6:0] round_width_select_width_o;
   logic same_value_test_o, above_test_o, below_test_o, no_order_test_o, trap_o, trap_seen;
   logic [2:0] trap_class_o, cls_seen;
   int failures = 0;
   int n_compared = 0;

   fpx_status_unit uut (.clk_sys_i, .rst_n_i, .null_restore_i, .mv_wr_i, .mv_sel_i,
      .mv_wdata_i, .mv_rdata_o, .op_start_i, .op_can_fault_i, .op_is_move_i, .op_arith_i,
      .op_addr_i, .op_done_i, .op_faults_i, .res_sign_i, .res_zero_i, .res_inf_i, .res_nan_i,
      .quot_valid_i, .quot_i, .mem_dest_i, .mem_fmt_i, .mant_i, .exp_i, .mant_o, .exp_o,
      .round_width_select_width_o, .rounding_mode_field_o, .same_value_test_o, .above_test_o,
      .below_test_o, .no_order_test_o, .trap_o, .trap_class_o);

   always #10 clk_sys_i = ~clk_sys_i;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Inputs change 1 ns after the rising edge so the design never races the bench.
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic wr(input logic [1:0] sel, input logic [31:0] d);
      mv_sel_i = sel;
      mv_wdata_i = d;
      mv_wr_i = 1'b1;
      tick();
      mv_wr_i = 1'b0;
      // Letting an edge pass keeps two writes in a row from toggling the strobe at once.
      tick();
   endtask

   task automatic rd(input logic [1:0] sel, output logic [31:0] d);
      mv_sel_i = sel;
      tick();
      d = mv_rdata_o;
   endtask

   task automatic op(input logic [31:0] addr, input logic fok, input logic mvop,
                     input logic [7:0] f, input logic [3:0] cc, input logic [7:0] q);
      op_start_i = 1'b1;
      op_can_fault_i = fok;
      op_is_move_i = mvop;
      op_addr_i = addr;
      tick();
      op_start_i = 1'b0;
      op_faults_i = f;
      tick();
      op_faults_i = 8'h00;
      op_done_i = 1'b1;
      op_arith_i = !mvop;
      {res_sign_i, res_zero_i, res_inf_i, res_nan_i} = cc;
      quot_valid_i = (q != 8'h00);
      quot_i = q;
      tick();
      op_done_i = 1'b0;
      quot_valid_i = 1'b0;
      trap_seen = trap_o;
      cls_seen = trap_class_o;
      tick();
      chk("trap_drop", trap_o, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_ops();
      logic [7:0] ft[8] = '{8'h12, 8'h08, 8'h0A, 8'h44, 8'h21, 8'h00, 8'h80, 8'h13};
      logic [3:0] cs[8] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'hA, 4'h1, 4'h9};
      logic [7:0] en, hit, f;
      logic [4:0] stk;
      logic [3:0] c;
      logic [2:0] cls;
      en = 8'h12;
      stk = 5'h0;
      wr(`FPX_SEL_CTRL, {16'h0, en, 8'h00});
      for (int i = 0; i < 8; i++) begin
         f = ft[i];
         c = cs[i];
         op(32'h1000_0000 + 32'(i * 4), 1'b1, 1'b0, f, c, 8'h00);
         stk = stk | {f[6] | f[5], f[4], f[3] & f[1], f[2], f[1] | f[0] | f[4]};
         hit = f & en;
         cls = 3'h0;
         for (int j = 0; j < 8; j++) if (hit[j]) cls = 3'(j);
         chk("trap", trap_seen, |hit);
         if (|hit) chk("trap_class", cls_seen, cls);
         rd(`FPX_SEL_STAT, v);
         chk("current", v[15:8], f);
         chk("sticky", v[7:3], stk);
         chk("class", v[27:24], c);
         chk("tests", {same_value_test_o, above_test_o, below_test_o, no_order_test_o},
             {c[2], ~c[3] & ~c[2] & ~c[0], c[3] & ~c[2] & ~c[0], c[0]});
         rd(`FPX_SEL_FIAR, v);
         chk("fault_addr", v, 32'h1000_0000 + 32'(i * 4));
      end
      op(32'h2000_0040, 1'b1, 1'b0, 8'h04, 4'h8, 8'hA5);
      rd(`FPX_SEL_STAT, w);
      chk("quotient", w[23:16], 8'hA5);
      chk("dz_sticky", w[4], 1'b1);
      op(32'h5555_0000, 1'b0, 1'b1, 8'h00, 4'h2, 8'h00);
      chk("move_trap", trap_seen, 1'b0);
      rd(`FPX_SEL_STAT, v);
      chk("move_status", v, w);
      rd(`FPX_SEL_FIAR, v);
      chk("move_addr", v, 32'h2000_0040);
      $display("test_ops done");
   endtask

   task automatic test_software();
      wr(`FPX_SEL_CTRL, 32'hFFFF_FF30);
      rd(`FPX_SEL_CTRL, v);
      chk("control_rw", v, 32'h0000_FF30);
      chk("rounding", rounding_mode_field_o, 2'h3);
      wr(`FPX_SEL_STAT, 32'hFFFF_FFFF);
      rd(`FPX_SEL_STAT, v);
      chk("status_rw", v, 32'h0FFF_FFF8);
      wr(`FPX_SEL_STAT, 32'h0000_FFF8);
      for (int i = 0; i < 3; i++) begin
         chk("sw_no_trap", trap_o, 1'b0);
         tick();
      end
      wr(`FPX_SEL_STAT, 32'h0000_0000);
      chk("sticky_clear_no_trap", trap_o, 1'b0);
      rd(`FPX_SEL_FIAR, v);
      chk("fiar_kept", v, 32'h2000_0040);
      op(32'h3000_0000, 1'b1, 1'b1, 8'h04, 4'h0, 8'h00);
      chk("move_trap_taken", trap_seen, 1'b1);
      chk("move_trap_class", cls_seen, 3'h2);
      rd(`FPX_SEL_STAT, v);
      chk("move_current", v[15:8], 8'h04);
      chk("move_sticky", v[7:3], 5'h00);
      rd(`FPX_SEL_FIAR, v);
      chk("move_fault_addr", v, 32'h3000_0000);
      null_restore_i = 1'b1;
      wr(`FPX_SEL_STAT, 32'h0000_FFF8);
      null_restore_i = 1'b0;
      rd(`FPX_SEL_STAT, v);
      chk("null_status", v, 32'h0);
      rd(`FPX_SEL_FIAR, v);
      chk("null_fiar", v, 32'h0);
      rd(`FPX_SEL_CTRL, v);
      chk("null_control", v, 32'h0);
      chk("default_width", round_width_select_width_o, `FPX_MANT_EXT);
      $display("test_software done");
   endtask

   task automatic test_round();
      logic [6:0] wd[3] = '{`FPX_MANT_EXT, `FPX_MANT_SGL, `FPX_MANT_DBL};
      mant_i = 64'hFFFF_FFFF_FFFF_FFFF;
      exp_i = 15'h3FFF;
      for (int p = 0; p < 3; p++) begin
         wr(`FPX_SEL_CTRL, {24'h0, 2'(p), 6'h0});
         chk("width", round_width_select_width_o, wd[p]);
         chk("mantissa", mant_o, mant_i << (7'd64 - wd[p]));
         chk("exp_pass", exp_o, 15'h3FFF);
      end
      exp_i = 15'h7000;
      wr(`FPX_SEL_CTRL, 32'h0000_0040);
      chk("exp_range", exp_o <= 15'h407E, 1'b1);
      mem_dest_i = 1'b1;
      mem_fmt_i = 2'h1;
      wr(`FPX_SEL_CTRL, 32'h0000_0080);
      chk("mem_width", round_width_select_width_o, `FPX_MANT_SGL);
      mem_dest_i = 1'b0;
      $display("test_round done");
   endtask

   task automatic end_of_test();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (3) tick();
      rst_n_i = 1'b1;
      rd(`FPX_SEL_STAT, v);
      chk("reset_status", v, 32'h0);
      chk("reset_above", above_test_o, 1'b1);
      rd(`FPX_SEL_FIAR, v);
      chk("reset_fiar", v, 32'h0);
      test_ops();
      test_software();
      test_round();
      end_of_test();
   end

   // The whole run needs well under 200 cycles; 50 us leaves a wide margin.
   initial begin
      #50000;
      failures++;
      end_of_test();
   end
endmodule
